// ===== uvia_top.sv
/*
 * Upstream traffic-class windows, two-channel upstream arbiter and
 * aggressive stop of the secondary master, with its register file.
 * Assumes all inputs come from logic on mclk_in; one register access at
 * a time, answered one cycle later.
 */
`timescale 1ns/1ns
`default_nettype none
`include "uvia_consts.svh"

// Overview of operation
// [R1] aggressive mode: timing event stops secondary master mid-transfer
// [R2] aggressive mode needs timed setup plus bit 2 of isochrony control
// [R3] four windows label upstream memory traffic; unmatched traffic stays TC0
// [R4] window control bit 0 enables, bits 3:1 give the class
// [R5] three arbitration modes when VC1 enabled; strict priority after reset
// [R6] VC1 disabled means VC0 is always granted
// [R7] software sets isochrony enable and programs a window
// [R8] software maps each window class onto VC1 in the map field
// [R9] software sets channel enable bit 31 and identifier bits 26:24
// [R10] strict priority always serves pending VC1 before VC0
// [R11] general control bit 25 selects strict; zero selects table modes
// [R12] round-robin alternates between VC0 and VC1
// [R13] select field 000b round-robin, 001b weighted table
// [R14] weighted mode picks one channel per phase, low three bits id
// [R15] software gives one phase per channel identifier
// [R16] writing 1 to bit 0 copies visible table to working table
// [R17] pending bit reads 1 from table write until table loaded
// [R18] visible table is four words at 180h..18Ch, 32 entries
// [R19] software sets secondary arbiter select to 100b
// [R20] software keeps base and limit aligned, limit above base
// [R21] lowest numbered matching window supplies the class
module uvia_top
    import uvia_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic reg_space_in,
    input wire logic [11:2] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [3:0] reg_be_in,
    input wire logic [31:0] reg_wdata_in,
    output logic [31:0] reg_rdata_out,
    output logic reg_ack_out,
    input wire logic us_valid_in,
    input wire logic [31:0] us_addr_in,
    output logic tag_valid_out,
    output logic [2:0] tag_class_out,
    output logic tag_vc1_out,
    input wire logic vc0_req_in,
    input wire logic vc1_req_in,
    input wire logic link_ready_in,
    output logic grant_vc0_out,
    output logic grant_vc1_out,
    input wire logic timing_event_in,
    input wire logic sec_busy_in,
    output logic stop_master_out
);
    // ==========================================================
    // register file
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    logic [31:0] iso_ctrl;
    logic [31:0] gen_ctrl;
    logic [31:0] vc1_res;
    logic [2:0] arb_sel;
    logic [31:0] tbl_vis [0:3];
    logic [3:0] tbl_int [0:`UVIA_TBL_ENTRIES-1];
    logic pending;
    uvia_win_s win [0:`UVIA_NUM_WIN-1];
    logic [11:0] byte_addr;
    logic cfg_wr;
    logic mem_wr;
    logic tbl_wr;
    logic load_req;

    assign byte_addr = {reg_addr_in, 2'b00};
    assign cfg_wr = reg_wr_in && !reg_space_in;
    assign mem_wr = reg_wr_in && reg_space_in;
    assign tbl_wr = cfg_wr && byte_addr >= `UVIA_TBL_OFS
                    && byte_addr <= `UVIA_TBL_LAST_OFS; // [R18]
    assign load_req = cfg_wr && byte_addr == `UVIA_PVC_CTRL_OFS
                      && reg_be_in[0]
                      && reg_wdata_in[`UVIA_TBL_LOAD_BIT]; // [R16]

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            gen_ctrl <= `UVIA_GEN_CTRL_RST; // [R5]
            vc1_res <= 32'h0;
            arb_sel <= 3'h0;
        end else if (cfg_wr) begin
            case (byte_addr)
                `UVIA_GEN_CTRL_OFS: begin
                    gen_ctrl <= merge(gen_ctrl, reg_wdata_in, reg_be_in);
                end
                `UVIA_PVC_CTRL_OFS: begin
                    if (reg_be_in[0]) begin
                        arb_sel <= reg_wdata_in[`UVIA_ARB_SEL_LSB +: 3];
                    end
                end
                `UVIA_VC1_RES_OFS: begin
                    vc1_res <= merge(vc1_res, reg_wdata_in, reg_be_in);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            iso_ctrl <= 32'h0;
            for (int n = 0; n < `UVIA_NUM_WIN; n++) begin
                win[n] <= '0;
            end
        end else if (mem_wr) begin
            if (byte_addr == `UVIA_ISO_CTRL_OFS) begin
                iso_ctrl <= merge(iso_ctrl, reg_wdata_in, reg_be_in);
            end
            for (int n = 0; n < `UVIA_NUM_WIN; n++) begin
                if (byte_addr == `UVIA_WIN0_CTRL_OFS
                                 + 12'(n) * `UVIA_WIN_STRIDE
                    && reg_be_in[0]) begin
                    win[n].en <= reg_wdata_in[`UVIA_WIN_EN_BIT]; // [R4]
                    win[n].cls <= reg_wdata_in[`UVIA_WIN_CLS_LSB +: 3];
                end
                if (byte_addr == `UVIA_WIN0_CTRL_OFS
                                 + 12'(n) * `UVIA_WIN_STRIDE
                                 + `UVIA_WIN_BASE_DELTA) begin
                    win[n].base <= merge(win[n].base, reg_wdata_in,
                                         reg_be_in);
                end
                if (byte_addr == `UVIA_WIN0_CTRL_OFS
                                 + 12'(n) * `UVIA_WIN_STRIDE
                                 + `UVIA_WIN_LIMIT_DELTA) begin
                    win[n].limit <= merge(win[n].limit, reg_wdata_in,
                                          reg_be_in);
                end
            end
        end
    end

    // ==========================================================
    // visible and working channel tables
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int d = 0; d < 4; d++) begin
                tbl_vis[d] <= 32'h0;
            end
        end else if (tbl_wr) begin
            tbl_vis[byte_addr[3:2]] <= merge(tbl_vis[byte_addr[3:2]],
                                             reg_wdata_in, reg_be_in);
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int i = 0; i < `UVIA_TBL_ENTRIES; i++) begin
                tbl_int[i] <= 4'h0;
            end
        end else if (load_req) begin
            for (int i = 0; i < `UVIA_TBL_ENTRIES; i++) begin
                tbl_int[i] <= tbl_vis[i / 8][(i % 8) * 4 +: 4]; // [R16]
            end
        end
    end

    // a table write wins over a load in the same cycle
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pending <= 1'b0;
        end else if (tbl_wr) begin
            pending <= 1'b1; // [R17]
        end else if (load_req) begin
            pending <= 1'b0; // [R17]
        end
    end

    logic [31:0] next_rdata;
    always_comb begin
        next_rdata = 32'h0;
        if (reg_space_in) begin
            if (byte_addr == `UVIA_ISO_CTRL_OFS) begin
                next_rdata = iso_ctrl;
            end
            for (int n = 0; n < `UVIA_NUM_WIN; n++) begin
                if (byte_addr == `UVIA_WIN0_CTRL_OFS
                                 + 12'(n) * `UVIA_WIN_STRIDE) begin
                    next_rdata = {28'h0, win[n].cls, win[n].en};
                end
                if (byte_addr == `UVIA_WIN0_CTRL_OFS
                                 + 12'(n) * `UVIA_WIN_STRIDE
                                 + `UVIA_WIN_BASE_DELTA) begin
                    next_rdata = win[n].base;
                end
                if (byte_addr == `UVIA_WIN0_CTRL_OFS
                                 + 12'(n) * `UVIA_WIN_STRIDE
                                 + `UVIA_WIN_LIMIT_DELTA) begin
                    next_rdata = win[n].limit;
                end
            end
        end else begin
            case (byte_addr)
                `UVIA_GEN_CTRL_OFS: next_rdata = gen_ctrl;
                `UVIA_VC1_RES_OFS: next_rdata = vc1_res;
                `UVIA_PVC_CTRL_OFS: begin
                    next_rdata = {15'h0, pending, 12'h0, arb_sel, 1'b0};
                end
                default: begin
                    if (byte_addr >= `UVIA_TBL_OFS
                        && byte_addr <= `UVIA_TBL_LAST_OFS) begin
                        next_rdata = tbl_vis[byte_addr[3:2]];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            reg_rdata_out <= 32'h0;
            reg_ack_out <= 1'b0;
        end else begin
            reg_ack_out <= reg_rd_in || reg_wr_in;
            reg_rdata_out <= reg_rd_in ? next_rdata : 32'h0;
        end
    end

    // ==========================================================
    // traffic-class labelling
    logic ch_en;
    logic [2:0] ch_id;
    logic [2:0] next_class;
    assign ch_en = vc1_res[`UVIA_CH_EN_BIT];
    assign ch_id = vc1_res[`UVIA_CH_ID_LSB +: 3];

    always_comb begin
        next_class = 3'h0; // [R3]
        // walk downward so the lowest matching window is applied last
        for (int n = `UVIA_NUM_WIN - 1; n >= 0; n--) begin
            if (win[n].en && us_addr_in >= win[n].base
                && us_addr_in <= win[n].limit) begin
                next_class = win[n].cls; // [R21]
            end
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            tag_valid_out <= 1'b0;
            tag_class_out <= 3'h0;
            tag_vc1_out <= 1'b0;
        end else begin
            tag_valid_out <= us_valid_in;
            tag_class_out <= us_valid_in ? next_class : 3'h0; // [R3]
            tag_vc1_out <= us_valid_in && ch_en
                           && iso_ctrl[`UVIA_ISO_EN_BIT]
                           && vc1_res[`UVIA_MAP_LSB + next_class];
        end
    end

    // ==========================================================
    // upstream channel arbiter
    uvia_mode_e mode;
    logic [4:0] phase;
    logic last_vc1;
    logic decide;
    logic next_g0;
    logic next_g1;
    logic [3:0] entry;

    assign entry = tbl_int[phase];
    assign decide = link_ready_in && (vc0_req_in || vc1_req_in);

    always_comb begin
        if (gen_ctrl[`UVIA_STRICT_BIT]) begin
            mode = UVIA_STRICT; // [R11]
        end else if (arb_sel == `UVIA_SEL_WRR) begin
            mode = UVIA_WRR; // [R13]
        end else begin
            mode = UVIA_RR; // [R13]
        end
    end

    always_comb begin
        next_g0 = 1'b0;
        next_g1 = 1'b0;
        if (!decide) begin
            next_g0 = 1'b0;
        end else if (!ch_en || !vc1_req_in) begin
            next_g0 = vc0_req_in; // [R6]
        end else if (!vc0_req_in) begin
            next_g1 = 1'b1;
        end else begin
            case (mode)
                UVIA_STRICT: next_g1 = 1'b1; // [R10]
                UVIA_RR: next_g1 = !last_vc1; // [R12]
                UVIA_WRR: next_g1 = entry[2:0] == ch_id; // [R14]
                default: next_g1 = 1'b1;
            endcase
            next_g0 = !next_g1;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            grant_vc0_out <= 1'b0;
            grant_vc1_out <= 1'b0;
            last_vc1 <= 1'b0;
            phase <= 5'h0;
        end else begin
            grant_vc0_out <= next_g0;
            grant_vc1_out <= next_g1;
            if (next_g0 || next_g1) begin
                last_vc1 <= next_g1;
            end
            if (decide && mode == UVIA_WRR) begin
                phase <= phase + 5'h1; // [R14]
            end
        end
    end

    // ==========================================================
    // aggressive stop of the secondary master
    uvia_state_e state;
    logic aggressive;
    assign aggressive = iso_ctrl[`UVIA_TIMED_EN_BIT]
                        && iso_ctrl[`UVIA_AGGR_EN_BIT]
                        && vc1_res[`UVIA_SEC_SEL_LSB +: 3]
                           == `UVIA_SEC_TIMED; // [R2]

    // stop holds until the master leaves the bus
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state <= UVIA_IDLE;
        end else begin
            case (state)
                UVIA_IDLE: begin
                    if (aggressive && timing_event_in && sec_busy_in) begin
                        state <= UVIA_STOP; // [R1]
                    end
                end
                UVIA_STOP: begin
                    if (!sec_busy_in) begin
                        state <= UVIA_IDLE;
                    end
                end
                default: state <= UVIA_IDLE;
            endcase
        end
    end
    assign stop_master_out = state == UVIA_STOP;

    // ==========================================================
    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);

    property p_vc0_only;
        !ch_en |-> ##1 !grant_vc1_out;
    endproperty
    a_vc0_only: assert property (p_vc0_only) // [R6]
        else $error("vc1 granted while disabled");

    property p_strict;
        decide && ch_en && vc1_req_in && mode == UVIA_STRICT
        |=> grant_vc1_out && !grant_vc0_out;
    endproperty
    a_strict: assert property (p_strict) // [R10]
        else $error("strict mode did not serve vc1");

    property p_rr_alt;
        decide && ch_en && vc0_req_in && vc1_req_in && mode == UVIA_RR
        |=> grant_vc1_out != $past(last_vc1);
    endproperty
    a_rr_alt: assert property (p_rr_alt) // [R12]
        else $error("round robin did not alternate");

    property p_wrr_pick;
        decide && ch_en && vc0_req_in && vc1_req_in && mode == UVIA_WRR
        |=> grant_vc1_out == ($past(entry[2:0]) == $past(ch_id));
    endproperty
    a_wrr_pick: assert property (p_wrr_pick) // [R14]
        else $error("weighted pick wrong");

    property p_load_clears;
        load_req && !tbl_wr
        |=> !pending && tbl_int[0] == $past(tbl_vis[0][3:0]);
    endproperty
    a_load_clears: assert property (p_load_clears) // [R16]
        else $error("table load failed");

    property p_pending;
        tbl_wr |=> pending ##1 (pending || $past(load_req));
    endproperty
    a_pending: assert property (p_pending) // [R17]
        else $error("pending not set by table write");

    property p_unmatched;
        us_valid_in && !(win[0].en || win[1].en || win[2].en || win[3].en)
        |=> tag_valid_out && tag_class_out == 3'h0;
    endproperty
    a_unmatched: assert property (p_unmatched) // [R3]
        else $error("class given without window");

    property p_low_win;
        us_valid_in && win[0].en && us_addr_in >= win[0].base
        && us_addr_in <= win[0].limit |=> tag_class_out == $past(win[0].cls);
    endproperty
    a_low_win: assert property (p_low_win) // [R21]
        else $error("window 0 not preferred");

    property p_stop;
        aggressive && timing_event_in && sec_busy_in && state == UVIA_IDLE
        |=> stop_master_out;
    endproperty
    a_stop: assert property (p_stop) // [R1]
        else $error("master not stopped on event");

    property p_no_stop;
        !aggressive && state == UVIA_IDLE |=> !stop_master_out;
    endproperty
    a_no_stop: assert property (p_no_stop) // [R2]
        else $error("stop outside aggressive mode");
endmodule // uvia_top

`default_nettype wire

// ===== uvia_consts.svh
/*
 * Offsets, field positions, reset values and counts of the upstream
 * channel arbiter and isochronous window block.
 * Assumes byte offsets within their own space (config or memory window).
 */
`ifndef UVIA_CONSTS_SVH
`define UVIA_CONSTS_SVH

// ==========================================================
// memory window space
`define UVIA_ISO_CTRL_OFS 12'h004
`define UVIA_WIN0_CTRL_OFS 12'h008
`define UVIA_WIN_STRIDE 12'h00C
`define UVIA_WIN_BASE_DELTA 12'h004
`define UVIA_WIN_LIMIT_DELTA 12'h008
`define UVIA_NUM_WIN 4
`define UVIA_ISO_EN_BIT 0
`define UVIA_TIMED_EN_BIT 1
`define UVIA_AGGR_EN_BIT 2
`define UVIA_WIN_EN_BIT 0
`define UVIA_WIN_CLS_LSB 1

// ==========================================================
// configuration space
`define UVIA_GEN_CTRL_OFS 12'h0D4
`define UVIA_PVC_CTRL_OFS 12'h15C
`define UVIA_VC1_RES_OFS 12'h170
`define UVIA_TBL_OFS 12'h180
`define UVIA_TBL_LAST_OFS 12'h18C
`define UVIA_STRICT_BIT 25
`define UVIA_GEN_CTRL_RST 32'h0200_0000
`define UVIA_TBL_LOAD_BIT 0
`define UVIA_ARB_SEL_LSB 1
`define UVIA_PEND_BIT 16
`define UVIA_CH_EN_BIT 31
`define UVIA_CH_ID_LSB 24
`define UVIA_SEC_SEL_LSB 17
`define UVIA_MAP_LSB 0
`define UVIA_SEL_RR 3'h0
`define UVIA_SEL_WRR 3'h1
`define UVIA_SEC_TIMED 3'h4
`define UVIA_TBL_ENTRIES 32

`endif

// ===== uvia_pkg.sv
/*
 * Types of the upstream channel arbiter block.
 * Assumes uvia_consts.svh is included by the design file.
 */
`default_nettype none
package uvia_pkg;
    typedef enum logic [1:0] {
        UVIA_STRICT = 2'h0,
        UVIA_RR = 2'h1,
        UVIA_WRR = 2'h3
    } uvia_mode_e;

    typedef enum logic [1:0] {
        UVIA_IDLE = 2'h0,
        UVIA_STOP = 2'h1
    } uvia_state_e;

    typedef struct packed {
        logic en;
        logic [2:0] cls;
        logic [31:0] base;
        logic [31:0] limit;
    } uvia_win_s;
endpackage

`default_nettype wire

// ===== uvia_partner.sv
/*
 * Far-side model: upstream link readiness and one secondary bus master.
 * Assumes the bench commands stalls and transfers between clock edges.
 */
`timescale 1ns/1ns
`default_nettype none

// ==========================================================
// link partner and secondary master
module uvia_partner (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic stall_in,
    input wire logic start_in,
    input wire logic stop_in,
    output logic link_ready_out,
    output logic sec_busy_out
);
    logic [1:0] hold;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            link_ready_out <= 1'b0;
        end else begin
            // slow answer: ready stays low as long as a stall is asked
            link_ready_out <= !stall_in;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sec_busy_out <= 1'b0;
            hold <= 2'h0;
        end else if (start_in) begin
            sec_busy_out <= 1'b1;
        end else if (stop_in && sec_busy_out) begin
            // a stopped master needs a few cycles to get off the bus
            hold <= hold + 2'h1;
            if (hold == 2'h2) begin
                sec_busy_out <= 1'b0;
                hold <= 2'h0;
            end
        end
    end
endmodule // uvia_partner

`default_nettype wire

// ===== test_upstream_vc_and_isoc_arbiter.sv
/*
 * Self-checking bench of the upstream channel arbiter block.
 * Assumes uvia_top, uvia_pkg and the partner model are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
`include "uvia_consts.svh"

`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
    bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end

module test_upstream_vc_and_isoc_arbiter;
    import uvia_pkg::*;

    logic mclk_in, rst_in, reg_space_in, reg_wr_in, reg_rd_in;
    logic [11:2] reg_addr_in;
    logic [3:0] reg_be_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, us_addr_in;
    logic reg_ack_out, us_valid_in, tag_valid_out, tag_vc1_out;
    logic [2:0] tag_class_out;
    logic vc0_req_in, vc1_req_in, link_ready, grant_vc0_out, grant_vc1_out;
    logic timing_event_in, sec_busy, stop_master_out, stall, start;
    int bad_count, n_compared;
    logic [31:0] wb [4], wl [4], dw [4];
    logic [2:0] wc [4];
    logic we [4];
    logic [3:0] tbl [32];
    logic [7:0] cmap;
    int p;

    uvia_top u_uvia_top (.mclk_in(mclk_in), .rst_in(rst_in),
        .reg_space_in(reg_space_in), .reg_addr_in(reg_addr_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_be_in(reg_be_in), .reg_wdata_in(reg_wdata_in),
        .reg_rdata_out(reg_rdata_out), .reg_ack_out(reg_ack_out),
        .us_valid_in(us_valid_in), .us_addr_in(us_addr_in),
        .tag_valid_out(tag_valid_out), .tag_class_out(tag_class_out),
        .tag_vc1_out(tag_vc1_out), .vc0_req_in(vc0_req_in),
        .vc1_req_in(vc1_req_in), .link_ready_in(link_ready),
        .grant_vc0_out(grant_vc0_out), .grant_vc1_out(grant_vc1_out),
        .timing_event_in(timing_event_in), .sec_busy_in(sec_busy),
        .stop_master_out(stop_master_out));

    uvia_partner u_uvia_partner (.mclk_in(mclk_in), .rst_in(rst_in),
        .stall_in(stall), .start_in(start), .stop_in(stop_master_out),
        .link_ready_out(link_ready), .sec_busy_out(sec_busy));

    // ==========================================================
    // helpers
    initial begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end

    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // idle cycle after each access so strobes never re-rise in one step
    task automatic wr(input logic sp, input logic [11:0] o,
                      input logic [31:0] d);
        reg_space_in = sp;
        reg_addr_in = o[11:2];
        reg_wdata_in = d;
        reg_wr_in = 1'b1;
        @(negedge mclk_in);
        reg_wr_in = 1'b0;
        @(negedge mclk_in);
    endtask

    task automatic rd(input logic sp, input logic [11:0] o,
                      input logic [31:0] e, input string nm);
        reg_space_in = sp;
        reg_addr_in = o[11:2];
        reg_rd_in = 1'b1;
        @(negedge mclk_in);
        reg_rd_in = 1'b0;
        `CHK(nm, e, reg_rdata_out)
        `CHK("reg_ack", 1'b1, reg_ack_out)
        @(negedge mclk_in);
    endtask

    task automatic arb(input logic r0, input logic r1,
                       input logic e0, input logic e1);
        vc0_req_in = r0;
        vc1_req_in = r1;
        @(negedge mclk_in);
        `CHK("grant_vc0", e0, grant_vc0_out)
        `CHK("grant_vc1", e1, grant_vc1_out)
    endtask

    task automatic idle(input int n);
        vc0_req_in = 1'b0;
        vc1_req_in = 1'b0;
        repeat (n) @(negedge mclk_in);
    endtask

    function automatic logic [2:0] exp_cls(input logic [31:0] a);
        for (int n = 0; n < 4; n++)
            if (we[n] && a >= wb[n] && a <= wl[n]) return wc[n];
        return 3'h0;
    endfunction

    task automatic tag(input logic [31:0] a);
        logic [2:0] c;
        c = exp_cls(a);
        us_addr_in = a;
        @(negedge mclk_in);
        `CHK("tag_valid", 1'b1, tag_valid_out)
        `CHK("tag_class", c, tag_class_out)
        `CHK("tag_vc1", cmap[c], tag_vc1_out)
    endtask

    initial begin
        #100000;
        bad_count++;
        end_of_test();
    end

    // ==========================================================
    // main sequence
    initial begin
        {reg_space_in, reg_wr_in, reg_rd_in, us_valid_in} = 4'h0;
        {vc0_req_in, vc1_req_in, timing_event_in, stall, start} = 5'h00;
        reg_addr_in = 10'h000;
        reg_be_in = 4'hF;
        reg_wdata_in = 32'h0000_0000;
        us_addr_in = 32'h0000_0000;
        bad_count = 0;
        n_compared = 0;
        cmap = 8'h8A;
        rst_in = 1'b1;
        repeat (3) @(negedge mclk_in);
        rst_in = 1'b0;
        p = $urandom(42);
        rd(0, `UVIA_GEN_CTRL_OFS, `UVIA_GEN_CTRL_RST, "gen_ctrl");
        rd(0, `UVIA_PVC_CTRL_OFS, 32'h0000_0000, "pvc_ctrl");
        rd(1, 12'hFF0, 32'h0000_0000, "unmapped");
        arb(1'b1, 1'b1, 1'b1, 1'b0);
        arb(1'b0, 1'b1, 1'b0, 1'b0);
        idle(1);
        wr(0, `UVIA_VC1_RES_OFS, 32'h8108_008A);
        rd(0, `UVIA_VC1_RES_OFS, 32'h8108_008A, "vc1_res");
        for (int i = 0; i < 3; i++) arb(1'b1, 1'b1, 1'b0, 1'b1);
        arb(1'b1, 1'b0, 1'b1, 1'b0);
        stall = 1'b1;
        idle(2);
        arb(1'b1, 1'b1, 1'b0, 1'b0);
        stall = 1'b0;
        idle(2);
        wr(0, `UVIA_GEN_CTRL_OFS, 32'h0000_0000);
        wr(0, `UVIA_PVC_CTRL_OFS, {28'h0, `UVIA_SEL_RR, 1'b0});
        arb(1'b1, 1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 6; i++) arb(1'b1, 1'b1, i[0], !i[0]);
        idle(1);
        p = $urandom_range(31, 0);
        for (int j = 0; j < 32; j++) begin
            tbl[j] = {$urandom_range(1, 0) == 1, 3'h0};
        end
        tbl[p][2:0] = 3'h1;
        for (int j = 0; j < 32; j++) dw[j / 8][(j % 8) * 4 +: 4] = tbl[j];
        for (int k = 0; k < 4; k++) wr(0, `UVIA_TBL_OFS + 12'(4 * k), dw[k]);
        rd(0, `UVIA_TBL_LAST_OFS, dw[3], "tbl_dw3");
        rd(0, `UVIA_PVC_CTRL_OFS, 32'h0001_0000, "pending");
        wr(0, `UVIA_PVC_CTRL_OFS, {28'h0, `UVIA_SEL_WRR, 1'b1});
        rd(0, `UVIA_PVC_CTRL_OFS, 32'h0000_0002, "loaded");
        for (int i = 0; i < 32; i++) arb(1'b1, 1'b1, i != p, i == p);
        idle(1);
        for (int n = 0; n < 4; n++) begin
            wb[n] = 32'h1000 + 32'h1800 * n;
            wl[n] = wb[n] + 32'h1FFC;
            wc[n] = 3'(2 * n + 1);
            we[n] = (n != 2);
            wr(1, `UVIA_WIN0_CTRL_OFS + `UVIA_WIN_STRIDE * 12'(n),
               {28'h0, wc[n], we[n]});
            wr(1, `UVIA_WIN0_CTRL_OFS + `UVIA_WIN_STRIDE * 12'(n) + 12'h004,
               wb[n]);
            wr(1, `UVIA_WIN0_CTRL_OFS + `UVIA_WIN_STRIDE * 12'(n) + 12'h008,
               wl[n]);
        end
        rd(1, 12'h030, wb[3], "win3_base");
        wr(1, `UVIA_ISO_CTRL_OFS, 32'h0000_0001);
        us_valid_in = 1'b1;
        tag(wb[0]);
        tag(wl[0]);
        tag(wl[3] + 32'h4);
        tag(wb[2]);
        tag(32'h0000_0000);
        for (int i = 0; i < 24; i++) tag($urandom_range(32'h8FFF, 0) & ~3);
        us_valid_in = 1'b0;
        wr(1, `UVIA_ISO_CTRL_OFS, 32'h0000_0003);
        start = 1'b1;
        @(negedge mclk_in);
        start = 1'b0;
        timing_event_in = 1'b1;
        @(negedge mclk_in);
        timing_event_in = 1'b0;
        `CHK("stop_off", 1'b0, stop_master_out)
        wr(1, `UVIA_ISO_CTRL_OFS, 32'h0000_0007);
        timing_event_in = 1'b1;
        @(negedge mclk_in);
        timing_event_in = 1'b0;
        `CHK("stop_set", 1'b1, stop_master_out)
        for (int k = 0; k < 20 && sec_busy; k++) begin
            `CHK("stop_held", 1'b1, stop_master_out)
            @(negedge mclk_in);
        end
        @(negedge mclk_in);
        `CHK("stop_done", 1'b0, stop_master_out)
        end_of_test();
    end
endmodule // test_upstream_vc_and_isoc_arbiter

`default_nettype wire
